// ### pkg/clm_regs.vh
// Register map, field positions, reset values and link timing counts
// for the companion link master. Included by the design files by bare name.
`ifndef CLM_REGS_VH
`define CLM_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CLM_OFS_STATUS      8'h00
`define CLM_OFS_ADDR        8'h04
`define CLM_OFS_DATA        8'h08
`define CLM_OFS_DIV         8'h0C

// ----------------------------------------------------------------------
// Status register fields and reset values
// ----------------------------------------------------------------------
`define CLM_BIT_SOFT_RESET  7
`define CLM_BIT_LINK_ERR    6
`define CLM_BIT_ERR_EN      5
`define CLM_BIT_DONE_EN     4
`define CLM_BIT_BUSY        0
`define CLM_RST_SOFT_RESET  1'h1
`define CLM_RST_BUSY        1'h1
`define CLM_RST_DIV         8'h04

// ----------------------------------------------------------------------
// Link timing counts, in link clocks, frame lengths and CRC polynomial
// ----------------------------------------------------------------------
`define CLM_INIT_LINK_CLKS  6'd48
`define CLM_TOUT_LINK_CLKS  6'd16
`define CLM_ERRW_LINK_CLKS  6'd48
`define CLM_TX_BITS         5'd26
`define CLM_RX_BITS         5'd16
`define CLM_CRC_POLY        8'h07

`endif

// ### verilog/clm_engine.v
// Serial engine of the companion link master: link clock divider,
// request framing, response capture, CRC check, time-out and reset sequence.
// Uses the divider live; the register bank also accepts divider writes while the engine is busy.
`timescale 1ns/1ps
`include "clm_regs.vh"

module clm_engine (
	input  wire        clk,
	input  wire        resetn,
	input  wire        hold,
	input  wire [7:0]  div,
	input  wire        start,
	input  wire        rw,
	input  wire [7:0]  addr,
	input  wire [7:0]  wdata,
	output reg         done_q,
	output reg         fail_q,
	output reg         init_done_q,
	output reg  [7:0]  rdata_q,
	output reg         link_clk_q,
	output reg         link_dout_q,
	input  wire        link_din
);

localparam [2:0] S_HOLD = 3'd0;
localparam [2:0] S_INIT = 3'd1;
localparam [2:0] S_IDLE = 3'd2;
localparam [2:0] S_SEND = 3'd3;
localparam [2:0] S_WAIT = 3'd4;
localparam [2:0] S_RECV = 3'd5;
localparam [2:0] S_CHK  = 3'd6;
localparam [2:0] S_ERRW = 3'd7;

reg  [2:0]  state_q;
reg  [7:0]  dcnt_q;
reg  [5:0]  cnt_q;
reg  [4:0]  bits_q;
reg  [25:0] shift_q;
reg         rw_q;
reg         din_s1_q;
reg         din_s2_q;
wire        tick;

// ----------------------------------------------------------------------
// CRC-8, used on both the request and the read response
// ----------------------------------------------------------------------
function [7:0] crc8;
	input [23:0] d;
	integer i;
	reg [7:0] c;
	begin
		c = 8'h00;
		for (i = 23; i >= 0; i = i - 1) begin
			if (c[7] ^ d[i])
				c = {c[6:0], 1'b0} ^ `CLM_CRC_POLY;
			else
				c = {c[6:0], 1'b0};
		end
		crc8 = c;
	end
endfunction

// ----------------------------------------------------------------------
// Link clock divider: one tick per (div + 1) master clocks
// ----------------------------------------------------------------------
assign tick = (dcnt_q == div);

// High from the tick to the half period; divider of 0 leaves the pin high
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		dcnt_q     <= 8'h00;
		link_clk_q <= 1'b0;
	end else begin
		dcnt_q <= tick ? 8'h00 : dcnt_q + 8'h01;
		if (tick)
			link_clk_q <= 1'b1;
		else if (dcnt_q == {1'b0, div[7:1]})
			link_clk_q <= 1'b0;
	end
end

// Response pin comes from the companion, so it is synchronised first
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		din_s1_q <= 1'b1;
		din_s2_q <= 1'b1;
	end else begin
		din_s1_q <= link_din;
		din_s2_q <= din_s1_q;
	end
end

// ----------------------------------------------------------------------
// Transaction sequencer
// ----------------------------------------------------------------------
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		state_q     <= S_HOLD;
		cnt_q       <= 6'd0;
		bits_q      <= 5'd0;
		shift_q     <= 26'h3FFFFFF;
		rw_q        <= 1'b0;
		done_q      <= 1'b0;
		fail_q      <= 1'b0;
		init_done_q <= 1'b0;
		rdata_q     <= 8'h00;
		link_dout_q <= 1'b1;
	end else if (hold) begin
		// Abort anything in flight without reporting it
		state_q     <= S_HOLD;
		link_dout_q <= 1'b1;
		done_q      <= 1'b0;
		init_done_q <= 1'b0;
	end else begin
		done_q      <= 1'b0;
		init_done_q <= 1'b0;
		case (state_q)
		S_HOLD: begin
			cnt_q   <= 6'd0;
			state_q <= S_INIT;
		end
		S_INIT: if (tick) begin
			if (cnt_q == `CLM_INIT_LINK_CLKS - 6'd1) begin
				init_done_q <= 1'b1;
				state_q     <= S_IDLE;
			end else
				cnt_q <= cnt_q + 6'd1;
		end
		S_IDLE: if (start) begin
			shift_q <= {1'b0, rw, addr, wdata, crc8({7'h00, rw, addr, wdata})};
			bits_q  <= `CLM_TX_BITS;
			rw_q    <= rw;
			state_q <= S_SEND;
		end
		S_SEND: if (tick) begin
			if (bits_q != 5'd0) begin
				link_dout_q <= shift_q[25];
				shift_q     <= {shift_q[24:0], 1'b1};
				bits_q      <= bits_q - 5'd1;
			end else begin
				link_dout_q <= 1'b1;
				cnt_q       <= 6'd0;
				state_q     <= S_WAIT;
			end
		end
		S_WAIT: if (tick) begin
			// A low start bit is the companion's answer
			if (!din_s2_q) begin
				if (rw_q) begin
					bits_q  <= `CLM_RX_BITS;
					state_q <= S_RECV;
				end else begin
					done_q  <= 1'b1;
					fail_q  <= 1'b0;
					state_q <= S_IDLE;
				end
			end else if (cnt_q == `CLM_TOUT_LINK_CLKS - 6'd1) begin
				cnt_q   <= 6'd0;
				state_q <= S_ERRW;
			end else
				cnt_q <= cnt_q + 6'd1;
		end
		S_RECV: if (tick) begin
			shift_q <= {shift_q[24:0], din_s2_q};
			bits_q  <= bits_q - 5'd1;
			if (bits_q == 5'd1)
				state_q <= S_CHK;
		end
		S_CHK: begin
			if (crc8({16'h0000, shift_q[15:8]}) == shift_q[7:0]) begin
				rdata_q <= shift_q[15:8];
				done_q  <= 1'b1;
				fail_q  <= 1'b0;
				state_q <= S_IDLE;
			end else begin
				cnt_q   <= 6'd0;
				state_q <= S_ERRW;
			end
		end
		S_ERRW: if (tick) begin
			if (cnt_q == `CLM_ERRW_LINK_CLKS - 6'd1) begin
				done_q  <= 1'b1;
				fail_q  <= 1'b1;
				state_q <= S_IDLE;
			end else
				cnt_q <= cnt_q + 6'd1;
		end
		default: state_q <= S_HOLD;
		endcase
	end
end

endmodule // clm_engine

// ### verilog/clm_top.v
// Register bank of the companion link master and its control behaviour:
// soft reset, busy, error flag, interrupt outputs, address, data, divider.
// Assumes a simple synchronous register port from the embedded controller;
// read data appears one clock after the read strobe.
`timescale 1ns/1ps
`include "clm_regs.vh"

module clm_top (
	input  wire        clk,
	input  wire        resetn,
	input  wire [7:0]  reg_addr,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [31:0] reg_wdata,
	output reg  [31:0] reg_rdata_q,
	output reg         err_irq_q,
	output reg         done_irq_q,
	output wire        link_clk_q,
	output wire        link_dout_q,
	input  wire        link_din
);

reg         soft_reset_q;
reg         link_err_q;
reg         error_irq_enable_q;
reg         done_irq_enable_q;
reg         busy_q;
reg  [7:0]  comp_addr_q;
reg  [7:0]  data_q;
reg  [7:0]  div_q;
reg         busy_d;
reg         link_err_d;
reg         rd_pend_q;
reg         eng_rd_q;
// Decode results and engine handshake
wire        eng_done;
wire        eng_fail;
wire        eng_init_done;
wire [7:0]  eng_rdata;
wire        idle;
wire        sel_status;
wire        sel_addr;
wire        sel_data;
wire        sel_div;
wire        launch_rd;
wire        launch_wr;
wire        wr_status;
wire        rst_set;
wire        rd_second;

// ----------------------------------------------------------------------
// Address decode and launch conditions
// ----------------------------------------------------------------------
assign sel_status = (reg_addr == `CLM_OFS_STATUS);
assign sel_addr   = (reg_addr == `CLM_OFS_ADDR);
assign sel_data   = (reg_addr == `CLM_OFS_DATA);
assign sel_div    = (reg_addr == `CLM_OFS_DIV);
assign idle       = !busy_q && !soft_reset_q;
assign wr_status  = reg_wr && sel_status;
assign rst_set    = wr_status && reg_wdata[`CLM_BIT_SOFT_RESET];
// A write wins over a read in the same cycle
// Launches are refused while busy or in soft reset; software polls busy first
assign launch_wr  = reg_wr && sel_data && idle;
// A data read while idle launches, unless it is the second read of a pair
assign launch_rd  = reg_rd && !reg_wr && sel_data && idle && !rd_pend_q;
// The second read only collects the returned byte and starts nothing
assign rd_second  = reg_rd && !reg_wr && sel_data && idle && rd_pend_q;

// ----------------------------------------------------------------------
// Serial engine
// ----------------------------------------------------------------------
clm_engine u_engine (
	.clk         (clk),
	.resetn      (resetn),
	.hold        (soft_reset_q),
	.div         (div_q),
	.start       (launch_wr || launch_rd),
	.rw          (launch_rd),
	.addr        (comp_addr_q),
	.wdata       (launch_wr ? reg_wdata[7:0] : data_q),
	.done_q      (eng_done),
	.fail_q      (eng_fail),
	.init_done_q (eng_init_done),
	.rdata_q     (eng_rdata),
	.link_clk_q  (link_clk_q),
	.link_dout_q (link_dout_q),
	.link_din    (link_din)
);

// ----------------------------------------------------------------------
// Busy: set by soft reset or a launch, cleared only by the engine
// ----------------------------------------------------------------------
always @* begin
	busy_d = busy_q;
	if (rst_set || soft_reset_q)
		busy_d = 1'b1;
	else if (launch_wr || launch_rd)
		busy_d = 1'b1;
	else if (eng_done || eng_init_done)
		busy_d = 1'b0;
end

// ----------------------------------------------------------------------
// Status and control bits
// ----------------------------------------------------------------------
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		soft_reset_q       <= `CLM_RST_SOFT_RESET;
		busy_q             <= `CLM_RST_BUSY;
		link_err_q         <= 1'b0;
		error_irq_enable_q <= 1'b0;
		done_irq_enable_q  <= 1'b0;
	end else begin
		busy_q <= busy_d;
		if (wr_status) begin
			soft_reset_q       <= reg_wdata[`CLM_BIT_SOFT_RESET];
			error_irq_enable_q <= reg_wdata[`CLM_BIT_ERR_EN];
			done_irq_enable_q  <= reg_wdata[`CLM_BIT_DONE_EN];
		end
		// Flag follows its shared next-level logic, so the error interrupt
		// matches the flag whenever the error enable was already set the cycle before
		link_err_q <= link_err_d;
	end
end

// ----------------------------------------------------------------------
// Address, data and divider registers
// ----------------------------------------------------------------------
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		comp_addr_q <= 8'h00;
		data_q      <= 8'h00;
		div_q       <= `CLM_RST_DIV;
	end else begin
		if (reg_wr && sel_addr)
			comp_addr_q <= reg_wdata[7:0];
		// Data writes during a transfer are dropped to protect the frame
		if (launch_wr)
			data_q <= reg_wdata[7:0];
		else if (eng_done && !eng_fail && eng_rd_q)
			data_q <= eng_rdata;
		// Divider only moves in soft reset or while busy, never while idle
		if (reg_wr && sel_div && (soft_reset_q || busy_q))
			div_q <= reg_wdata[7:0];
	end
end

// Remembers whether the transfer in flight is a read
always @(posedge clk or negedge resetn) begin
	if (!resetn)
		eng_rd_q <= 1'b0;
	else if (launch_wr || launch_rd)
		eng_rd_q <= launch_rd;
end

// ----------------------------------------------------------------------
// Two-read protocol: the first data read launches, the second collects
// ----------------------------------------------------------------------
// Soft reset and a write launch forget a pending pair; a read that fails
// still needs its second read, which then returns the old byte.
// Without this flag every collecting read would start yet another read.
always @(posedge clk or negedge resetn) begin
	if (!resetn)
		rd_pend_q <= 1'b0;
	else if (soft_reset_q || launch_wr)
		rd_pend_q <= 1'b0;
	else if (launch_rd)
		rd_pend_q <= 1'b1;
	else if (rd_second)
		rd_pend_q <= 1'b0;
end

// ----------------------------------------------------------------------
// Interrupt outputs
// ----------------------------------------------------------------------
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		err_irq_q  <= 1'b0;
		done_irq_q <= 1'b0;
	end else begin
		err_irq_q  <= link_err_d && error_irq_enable_q;
		// Only transfer ends pulse this; the reset sequence end does not
		done_irq_q <= eng_done && done_irq_enable_q;
	end
end

// ----------------------------------------------------------------------
// Link error flag: next level, shared by the flag and the error interrupt
// ----------------------------------------------------------------------
// Hardware set beats a same-cycle software clear, so a failure that lands
// on the clearing write is never lost; the interrupt rises with the flag
// and falls in the cycle after a clear
always @* begin
	link_err_d = link_err_q;
	if (eng_done && eng_fail)
		link_err_d = 1'b1;
	else if (wr_status && reg_wdata[`CLM_BIT_LINK_ERR])
		link_err_d = 1'b0;
end

// ----------------------------------------------------------------------
// Register read-back; reserved bits and unmapped offsets read as zero
// ----------------------------------------------------------------------
always @(posedge clk or negedge resetn) begin
	if (!resetn)
		reg_rdata_q <= 32'h00000000;
	else if (reg_rd) begin
		if (sel_status)
			reg_rdata_q <= {24'h000000, soft_reset_q, link_err_q,
				error_irq_enable_q, done_irq_enable_q, 3'h0, busy_q};
		else if (sel_addr)
			reg_rdata_q <= {24'h000000, comp_addr_q};
		else if (sel_data)
			reg_rdata_q <= {24'h000000, data_q};
		else if (sel_div)
			reg_rdata_q <= {24'h000000, div_q};
		else
			reg_rdata_q <= 32'h00000000;
	end
end

endmodule // clm_top

// ### verification/clm_monitor.sv
// Port checker for the companion link master.
// Assumes software writes the divider only while soft reset is set.
`timescale 1ns/1ps
module clm_monitor (
	input wire        clk,
	input wire        resetn,
	input wire [7:0]  reg_addr,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_wdata,
	input wire [31:0] reg_rdata_q,
	input wire        err_irq_q,
	input wire        done_irq_q,
	input wire        link_clk_q,
	input wire        link_dout_q,
	input wire        link_din
);
	wire       st_wr = reg_wr && reg_addr == 8'h00;
	wire       st_rd = reg_rd && !reg_wr && reg_addr == 8'h00;
	wire       dat   = (reg_wr || reg_rd) && reg_addr == 8'h08;
	reg        sr_q, en_q, dn_q, xf_q, sr_rd_q;
	reg  [7:0] div_q;
	reg  [9:0] gap_q;

	// ------------------------------------------------------------
	// Mirror of control fields; status bits 7/5/4 always take writes
	// ------------------------------------------------------------
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sr_q    <= 1'b1;
			en_q    <= 1'b0;
			dn_q    <= 1'b0;
			xf_q    <= 1'b0;
			sr_rd_q <= 1'b0;
			div_q   <= 8'h04;
			gap_q   <= 10'h3FF;
		end else begin
			if (st_wr) begin
				sr_q <= reg_wdata[7];
				en_q <= reg_wdata[5];
				dn_q <= reg_wdata[4];
			end
			if (reg_wr && reg_addr == 8'h0C && sr_q)
				div_q <= reg_wdata[7:0];
			xf_q    <= (st_wr && reg_wdata[7]) ? 1'b0 : (xf_q || dat); // Soft reset forgets launches
			sr_rd_q <= st_rd;
			if ($rose(link_clk_q))
				gap_q <= 10'h001;
			else if (gap_q != 10'h3FF)
				gap_q <= gap_q + 10'h001; // Saturates across idle gaps
		end
	end

	a_reset_values:
	assert property (@(posedge clk) disable iff (!resetn) $rose(resetn) |->
		reg_rdata_q == 32'h0 && !err_irq_q && !done_irq_q && link_dout_q && !link_clk_q)
		else $error("outputs wrong after reset");
	a_rsvd_zero:
	assert property (@(posedge clk) disable iff (!resetn) reg_rdata_q[31:8] == 24'h0)
		else $error("reserved read bits not zero");
	a_soft_hold:
	assert property (@(posedge clk) disable iff (!resetn)
		sr_q && $past(sr_q) && $past(sr_q, 2) |-> link_dout_q)
		else $error("link active in soft reset");
	a_err_masked:
	assert property (@(posedge clk) disable iff (!resetn) !$past(en_q) |-> !err_irq_q)
		else $error("error irq while disabled");
	a_err_shown:
	assert property (@(posedge clk) disable iff (!resetn)
		sr_rd_q && reg_rdata_q[6] && reg_rdata_q[5] |-> err_irq_q)
		else $error("error irq missing");
	a_err_fall:
	assert property (@(posedge clk) disable iff (!resetn) $fell(err_irq_q) |->
		$past(st_wr && reg_wdata[6]) || $past(st_wr && !reg_wdata[5], 2))
		else $error("error irq dropped without cause");
	a_done_masked:
	assert property (@(posedge clk) disable iff (!resetn)
		!dn_q && !$past(dn_q) && !$past(dn_q, 2) |-> !done_irq_q)
		else $error("done irq while disabled");
	a_done_after_xfer:
	assert property (@(posedge clk) disable iff (!resetn) done_irq_q |-> xf_q)
		else $error("done irq without transfer");
	a_done_pulse:
	assert property (@(posedge clk) disable iff (!resetn) done_irq_q |=> !done_irq_q)
		else $error("done irq longer than a cycle");
	a_link_period:
	assert property (@(posedge clk) disable iff (!resetn)
		$rose(link_clk_q) |-> gap_q >= {2'b00, div_q} + 10'h001)
		else $error("link clock too fast");
endmodule // clm_monitor

bind clm_top clm_monitor u_mon (
	.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
	.err_irq_q(err_irq_q), .done_irq_q(done_irq_q), .link_clk_q(link_clk_q),
	.link_dout_q(link_dout_q), .link_din(link_din)
);

// ### verification/clm_companion.sv
// Behavioural companion chip with 256 byte registers on the serial link.
// Assumes frames of start, rw, address, data and check byte, MSB first.
`timescale 1ns/1ps
module clm_companion (
	input  wire       resetn,
	input  wire       link_clk,
	input  wire       link_dout,
	input  wire [1:0] mode,
	input  wire [3:0] lag,
	output reg        link_din
);
	reg  [7:0]  mem [0:255];
	reg  [25:0] rx;
	reg  [5:0]  nrx;
	reg  [4:0]  wt;
	reg  [4:0]  ntx;
	reg  [16:0] tx;
	wire [7:0]  rb = mem[rx[23:16]];

	// Check byte, polynomial 07h, from zero
	function [7:0] crc8(input [23:0] v);
		integer k;
		begin
			crc8 = 8'h00;
			for (k = 23; k >= 0; k = k - 1)
				crc8 = {crc8[6:0], 1'b0} ^ ((crc8[7] ^ v[k]) ? 8'h07 : 8'h00);
		end
	endfunction

	// Capture on the falling link edge, mid-bit
	always @(negedge link_clk or negedge resetn) begin
		if (!resetn)
			nrx <= 6'd0;
		else if (nrx == 6'd26)
			nrx <= 6'd0;
		else if (nrx != 6'd0 || !link_dout) begin
			rx  <= {rx[24:0], link_dout};
			nrx <= nrx + 6'd1;
		end
	end

	// Answer after lag link clocks; drive on the rising edge for a full bit of setup
	always @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			wt       <= 5'd0;
			ntx      <= 5'd0;
			link_din <= 1'b1;
		end else if (nrx == 6'd26)
			wt <= 5'd1;
		else if (wt == {1'b0, lag}) begin
			wt <= 5'd0;
			if (mode != 2'd1 && crc8({7'h00, rx[24:8]}) == rx[7:0]) begin
				ntx <= rx[24] ? 5'd17 : 5'd1;
				tx  <= {1'b0, rb, crc8({16'h0, rb}) ^ {7'h00, mode == 2'd2}};
				if (!rx[24])
					mem[rx[23:16]] <= rx[15:8];
			end
		end else if (wt != 5'd0)
			wt <= wt + 5'd1;
		else if (ntx != 5'd0) begin
			link_din <= tx[16];
			tx       <= {tx[15:0], 1'b1};
			ntx      <= ntx - 5'd1;
		end else
			link_din <= 1'b1; // Released line sits at its idle high
	end
endmodule // clm_companion

// ### verification/clm_top_tb_top.sv
// Self-checking bench for the companion link master register bank.
// Assumes the companion model on the serial pins and the bound checker.
`timescale 1ns/1ps
module clm_top_tb_top;
	reg         clk;
	reg         resetn;
	reg  [7:0]  reg_addr;
	reg         reg_wr;
	reg         reg_rd;
	reg  [31:0] reg_wdata;
	wire [31:0] reg_rdata_q;
	wire        err_irq_q;
	wire        done_irq_q;
	wire        link_clk_q;
	wire        link_dout_q;
	wire        link_din;
	reg  [1:0]  mode;
	reg  [3:0]  lag;
	reg  [31:0] rv;
	reg  [7:0]  a;
	reg  [7:0]  d;
	time        tl;
	time        per;
	integer     n_errors, n_tests, n_done, nd, cyc, seed, i;

	clm_top dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
		.err_irq_q(err_irq_q), .done_irq_q(done_irq_q), .link_clk_q(link_clk_q),
		.link_dout_q(link_dout_q), .link_din(link_din));
	clm_companion u_comp (.resetn(resetn), .link_clk(link_clk_q), .link_dout(link_dout_q),
		.mode(mode), .lag(lag), .link_din(link_din));

	// ------------------------------------------------------------
	// Clock, hang guard, interrupt and link clock watchers
	// ------------------------------------------------------------
	initial clk = 1'b0;
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (done_irq_q === 1'b1)
			n_done = n_done + 1;
		if (cyc == 40000) begin
			n_errors = n_errors + 1;
			test_done;
		end
	end
	// Shortest link clock period seen, so idle gaps do not matter
	always @(posedge link_clk_q) begin
		if ($time - tl < per)
			per = $time - tl;
		tl = $time;
	end

	task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task wr(input [7:0] ad, input [31:0] v);
		begin
			@(negedge clk);
			reg_addr = ad;
			reg_wdata = v;
			reg_wr = 1'b1;
			@(negedge clk);
			reg_wr = 1'b0;
		end
	endtask
	task rd(input [7:0] ad, output [31:0] v);
		begin
			@(negedge clk);
			reg_addr = ad;
			reg_rd = 1'b1;
			@(negedge clk);
			reg_rd = 1'b0;
			@(negedge clk);
			v = reg_rdata_q;
		end
	endtask
	// Poll busy, bounded
	task idle;
		integer k;
		begin
			k = 0;
			rv = 32'h1;
			while (rv[0] !== 1'b0 && k < 500) begin
				rd(8'h00, rv);
				k = k + 1;
			end
			chk("busy end", 32'h0, {31'h0, rv[0]});
		end
	endtask
	task xfer(input rw_i, input [7:0] ad, input [7:0] dv);
		begin
			wr(8'h04, {24'h0, ad});
			if (rw_i)
				rd(8'h08, rv);
			else
				wr(8'h08, {24'h0, dv});
			rd(8'h00, rv);
			chk("busy set", 32'h1, {31'h0, rv[0]});
			idle;
		end
	endtask
	task test_done;
		begin
			$display("tests %0d errors %0d", n_tests, n_errors);
			if (n_errors == 0 && n_tests > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask

	initial begin
		seed = 32'hC296;
		{n_errors, n_tests, n_done, cyc} = 128'h0;
		{resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = 43'h0;
		{mode, lag, tl, per} = {2'd0, 4'd1, 64'h0, 64'hFFFF};
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		// Reset values, one unmapped offset among them
		for (i = 0; i < 5; i = i + 1) begin
			rd(8'h04 * i[7:0], rv);
			chk("reset val", i == 0 ? 32'h81 : (i == 3 ? 32'h4 : 32'h0), rv);
		end
		wr(8'h0C, 32'hFFFFFF03);
		rd(8'h0C, rv);
		chk("divider", 32'h3, rv);
		wr(8'h04, 32'hFFFFFF5A);
		rd(8'h04, rv);
		chk("address", 32'h5A, rv);
		wr(8'h00, 32'hFFFFFF1F);
		rd(8'h00, rv);
		chk("status", 32'h11, rv);
		repeat (160) @(negedge clk);
		rd(8'h00, rv);
		chk("busy hold", 32'h1, {31'h0, rv[0]});
		idle;
		chk("no done", 32'h0, n_done);
		wr(8'h0C, 32'h7);
		rd(8'h0C, rv);
		chk("div lock", 32'h3, rv);
		for (i = 0; i < 6; i = i + 1) begin
			rv = $random(seed);
			a = rv[7:0];
			d = rv[15:8];
			lag = i[0] ? 4'd9 : 4'd1;
			xfer(1'b0, a, d);
			chk("status", 32'h10, rv);
			xfer(1'b1, a, 8'h00);
			rd(8'h08, rv);
			chk("read data", {24'h0, d}, rv);
			chk("done count", 2 * i + 2, n_done);
		end
		chk("link per", 32'd32, per[31:0]);
		mode = 2'd1;
		xfer(1'b0, 8'h11, 8'h22);
		chk("timeout", 32'h50, rv);
		chk("irq off", 32'h0, {31'h0, err_irq_q});
		wr(8'h00, 32'h30);
		repeat (2) @(negedge clk);
		chk("irq on", 32'h1, {31'h0, err_irq_q});
		rd(8'h00, rv);
		chk("w0 keeps", 32'h70, rv);
		wr(8'h00, 32'h70);
		rd(8'h00, rv);
		chk("w1 clears", 32'h30, rv);
		chk("irq gone", 32'h0, {31'h0, err_irq_q});
		mode = 2'd2;
		xfer(1'b1, a, 8'h00);
		chk("bad check", 32'h70, rv);
		chk("irq crc", 32'h1, {31'h0, err_irq_q});
		mode = 2'd0;
		wr(8'h00, 32'h50);
		wr(8'h00, 32'h90);
		rd(8'h00, rv);
		chk("soft busy", 32'h91, rv);
		nd = n_done;
		wr(8'h00, 32'h10);
		idle;
		chk("no done", nd, n_done);
		// Reset again in mid-transfer
		wr(8'h08, 32'h05);
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		rd(8'h00, rv);
		chk("re-reset", 32'h81, rv);
		rd(8'h0C, rv);
		chk("re-div", 32'h4, rv);
		test_done;
	end
endmodule // clm_top_tb_top
